/* File: src/sgs_pkg.sv */
// Purpose: Shared constants and types for the parameter bank selector
// Assumes: One system clock, asynchronous active-low reset
// Notes: Bank indices are zero based, index 0 is bank one

package sgs_pkg;

   // Bank count and elaboration limit
   localparam int BANK_NUM = 8;
   localparam int BANK_MAX = 16;

   // Reset value of the active bank index (bank one)
   localparam int ACT_RST = 0;

   // Selector code meaning "no bank requested"
   localparam int SEL_NONE = 0;

   // Reset value of the previous-enable mask (only bank one enabled)
   localparam int EN_RST = 1;

   // Operating modes of the selector
   typedef enum logic [1:0] {
      SGS_SINGLE,
      SGS_AUTO,
      SGS_FORCE
   } sgs_mode_t;

endpackage : sgs_pkg

/* File: src/sgs_selector.sv */
// Purpose: Chooses one of the parameter banks from requests, remote and override
// Assumes: Inputs synchronous to ref_clk; remote_stb is a one-cycle strobe
// Notes: Index 0 is bank one, the highest priority
//
// How it works
// (R1) Eight bank requests ranked by fixed priority; bank one highest wins collisions.
// (R2) Bank one held high blocks every other bank request.
// (R3) Any held request blocks lower banks; higher banks still accepted.
// (R4) Bank eight held level suppresses nothing.
// (R5) Requests work as short pulses or as held levels.
// (R6) Forced change only with override enabled and an enabled target bank.
// (R7) Override enable masks automatic control until cleared.
// (R8) Forced bank acts as a pulse; it stays after release without requests.
// (R9) Held request levels at override release take over the selection.
// (R10) Remote change refused while a higher bank request is held.
// (R11) Used-bank count enables bank one up to all; new banks load defaults.
// (R12) Active bank index is readable; bank one after reset.
// (R13) Override select is none or a bank; it wins once enabled.
// (R14) Host sets override enable before forcing; it resets disabled.
// (R15) A pulse-activated bank stays until another bank is activated.
// (R16) With only bank one enabled the selector idles on bank one.
// (R17) Evaluated each cycle; active bank registered one cycle later.

`timescale 1ns/1ps

module sgs_selector
   import sgs_pkg::*;
#(
   parameter int NBANK = BANK_NUM,
   localparam int IW = $clog2(NBANK),
   localparam int SW = $clog2(NBANK + 1)
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [NBANK-1:0] bank_req,
   input wire logic [IW-1:0] used_banks,
   input wire logic override_en,
   input wire logic [SW-1:0] override_sel,
   input wire logic remote_stb,
   input wire logic [SW-1:0] remote_sel,
   output logic [IW-1:0] active_bank,
   output logic [NBANK-1:0] active_onehot,
   output logic [NBANK-1:0] bank_enabled,
   output logic [NBANK-1:0] bank_load_default,
   output logic remote_reject,
   output logic override_reject
);

   // Refuse bank counts the index widths cannot serve
   if (NBANK < 2 || NBANK > BANK_MAX) begin : g_chk
      $error("sgs_selector: NBANK out of range");
   end

   // Lowest set index wins, which is the highest priority
   function automatic logic [IW:0] pri_first(input logic [NBANK-1:0] m);
      logic [IW:0] r;
      r = '0;
      for (int i = NBANK - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = {1'b1, IW'(i)};
         end
      end
      return r;
   endfunction : pri_first

   sgs_mode_t state_ff;
   sgs_mode_t nxt_state;
   logic [IW-1:0] act_ff;
   logic [IW-1:0] nxt_act;
   logic [NBANK-1:0] onehot_ff;
   logic [NBANK-1:0] nxt_onehot;
   logic [NBANK-1:0] req_prev_ff;
   logic [NBANK-1:0] en_prev_ff;
   logic [NBANK-1:0] load_ff;
   logic rrej_ff;
   logic frej_ff;

   wire [NBANK-1:0] en_mask;
   wire [NBANK-1:0] req_lvl;
   wire [NBANK-1:0] rise;
   wire [NBANK-1:0] blk;
   wire [NBANK-1:0] acc;
   wire [IW:0] win_hit;
   wire [IW:0] lvl_hit;
   wire win_any;
   wire [IW-1:0] win_idx;
   wire lvl_any;
   wire [IW-1:0] lvl_idx;
   wire single;
   wire rel_take;
   wire auto_go;
   wire act_ok;
   wire fsel_ok;
   wire [IW-1:0] f_idx;
   wire rsel_ok;
   wire [IW-1:0] r_idx;
   wire higher_busy;
   wire remote_ok;
   wire remote_win;

   // Enable mask, suppression chain and one-hot decode per bank
   for (genvar g = 0; g < NBANK; g++) begin : g_bank
      assign en_mask[g] = (IW'(g) <= used_banks); // R11
      assign nxt_onehot[g] = (nxt_act == IW'(g));
      if (g == 0) begin : g_top
         assign blk[g] = 1'b0;
      end else begin : g_low
         // Any held level above blocks this bank; bank eight blocks no one
         assign blk[g] = blk[g-1] | req_lvl[g-1]; // R3 R4
      end
   end

   // Request qualification: levels suppress, edges activate
   assign req_lvl = bank_req & en_mask; // R2 R3
   assign rise = req_lvl & ~req_prev_ff; // R5
   assign acc = rise & ~blk; // R3
   assign win_hit = pri_first(acc); // R1
   assign win_any = win_hit[IW];
   assign win_idx = win_hit[IW-1:0];
   assign lvl_hit = pri_first(req_lvl);
   assign lvl_any = lvl_hit[IW];
   assign lvl_idx = lvl_hit[IW-1:0];

   // Mode qualifiers
   assign single = (used_banks == '0); // R16
   assign rel_take = (state_ff == SGS_FORCE) && !override_en && lvl_any; // R9
   assign auto_go = !single && !override_en;
   assign act_ok = (act_ff <= used_banks);

   // Forced target must be a real, enabled bank
   assign fsel_ok = (override_sel != SW'(SEL_NONE)) && (override_sel <= SW'(used_banks) + SW'(1)); // R6 R13
   assign f_idx = IW'(override_sel - SW'(1));

   // Remote target check against held higher-priority levels
   assign rsel_ok = (remote_sel != SW'(SEL_NONE)) && (remote_sel <= SW'(used_banks) + SW'(1));
   assign r_idx = IW'(remote_sel - SW'(1));
   assign higher_busy = lvl_any && (lvl_idx < r_idx); // R10
   assign remote_ok = remote_stb && rsel_ok && !higher_busy && auto_go; // R10
   assign remote_win = remote_ok && (!win_any || (r_idx < win_idx));

   // Mode selection; override dominates automatic control
   always_comb begin
      if (single) begin
         nxt_state = SGS_SINGLE;
      end else if (override_en) begin
         nxt_state = SGS_FORCE; // R7
      end else begin
         nxt_state = SGS_AUTO;
      end
   end

   // Next active bank; dropped banks fall back to bank one
   always_comb begin
      nxt_act = act_ff;
      case (nxt_state)
         SGS_SINGLE: begin
            nxt_act = IW'(ACT_RST); // R16
         end
         SGS_FORCE: begin
            if (fsel_ok) begin
               nxt_act = f_idx; // R6 R13
            end else if (!act_ok) begin
               nxt_act = IW'(ACT_RST);
            end
         end
         SGS_AUTO: begin
            if (rel_take) begin
               nxt_act = lvl_idx; // R9
            end else if (remote_win) begin
               nxt_act = r_idx; // R10
            end else if (win_any) begin
               nxt_act = win_idx; // R1
            end else if (!act_ok) begin
               nxt_act = IW'(ACT_RST);
            end
            // Otherwise hold: pulses and released overrides persist (R8 R15)
         end
         default: begin
            nxt_act = IW'(ACT_RST);
         end
      endcase
   end

   // Mode and active bank registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SGS_SINGLE;
         act_ff <= IW'(ACT_RST); // R12
         onehot_ff <= NBANK'(EN_RST);
      end else begin
         state_ff <= nxt_state;
         act_ff <= nxt_act; // R17
         onehot_ff <= nxt_onehot;
      end
   end

   // Edge history; a level held through reset counts as a fresh edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_prev_ff <= '0;
      end else begin
         req_prev_ff <= req_lvl;
      end
   end

   // Newly enabled banks get a one-cycle default-load pulse
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_prev_ff <= NBANK'(EN_RST);
         load_ff <= '0;
      end else begin
         en_prev_ff <= en_mask;
         load_ff <= en_mask & ~en_prev_ff; // R11
      end
   end

   // Refusal flags: remote is a pulse, override refusal a level
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rrej_ff <= 1'b0;
         frej_ff <= 1'b0;
      end else begin
         rrej_ff <= remote_stb && !remote_ok; // R10
         frej_ff <= override_en && !single && (override_sel != SW'(SEL_NONE)) && !fsel_ok; // R6
      end
   end

   // Output drive, all from flip-flops
   assign active_bank = act_ff;
   assign active_onehot = onehot_ff;
   assign bank_enabled = en_prev_ff;
   assign bank_load_default = load_ff;
   assign remote_reject = rrej_ff;
   assign override_reject = frej_ff;

   // Checks on the selection behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   AST_PRIORITY: assert property ( // R1
      auto_go && !rel_take && !remote_win && win_any |=> active_bank == $past(win_idx))
      else $error("winning request edge not taken");

   AST_BANK_ONE_HOLD: assert property ( // R2
      auto_go && bank_req[0] && active_bank == '0 |=> active_bank == '0)
      else $error("bank one left while its level held");

   AST_STATIC_BLOCKS: assert property ( // R3
      auto_go && !rel_take && req_lvl[active_bank] |=> active_bank <= $past(active_bank))
      else $error("lower bank displaced a held level");

   // Bank seven edge with nothing higher held or rising, bank eight held
   AST_EIGHT_NO_BLOCK: assert property ( // R4
      auto_go && !rel_take && !remote_stb && rise[NBANK-2] && req_lvl[NBANK-1]
      && lvl_idx == IW'(NBANK - 2)
      |=> active_bank == IW'(NBANK - 2))
      else $error("bank eight level blocked a request");

   AST_FORCE_NEEDS_OK: assert property ( // R6
      override_en && !single && !fsel_ok && act_ok |=> $stable(active_bank))
      else $error("forced change without valid target");

   AST_FORCE_TAKES: assert property ( // R7
      override_en && !single && fsel_ok ##1 override_en && !single && fsel_ok
      |=> active_bank == $past(f_idx))
      else $error("override did not hold its bank");

   AST_RELEASE_HOLD: assert property ( // R8
      state_ff == SGS_FORCE && auto_go && !lvl_any && !remote_ok && act_ok |=> $stable(active_bank))
      else $error("forced bank lost after release");

   AST_RELEASE_LEVEL: assert property ( // R9
      rel_take && !single |=> active_bank == $past(lvl_idx))
      else $error("held level ignored at release");

   AST_REMOTE_BLOCK: assert property ( // R10
      remote_stb && higher_busy
      |=> remote_reject && (active_bank != $past(r_idx) || $past(act_ff) == $past(r_idx) || !$past(auto_go)))
      else $error("remote beat a higher held request");

   AST_LOAD_PULSE: assert property ( // R11
      $rose(en_mask[NBANK-1]) |=> bank_load_default[NBANK-1] ##1 !bank_load_default[NBANK-1])
      else $error("default load pulse missing");

   AST_PULSE_STAYS: assert property ( // R15
      auto_go && !rel_take && !win_any && !remote_ok && act_ok |=> $stable(active_bank))
      else $error("pulse bank dropped without new request");

   AST_SINGLE_IDLE: assert property ( // R16
      single |=> active_bank == '0 && active_onehot[0])
      else $error("single bank mode not on bank one");

   COV_PULSE_SWITCH: cover property (
      auto_go && rise[1] ##1 !bank_req[1] ##1 active_bank == IW'(1));
   COV_FORCE_RELEASE: cover property (
      override_en && fsel_ok ##1 !override_en && lvl_any);
   COV_REMOTE_OK: cover property (
      remote_ok ##1 !remote_reject);
   COV_REMOTE_REJ: cover property (
      remote_stb && higher_busy);

endmodule : sgs_selector

/* File: tb/sgs_host_model.sv */
// Purpose: Far side of the bank selector: digital inputs and supervisory host
// Assumes: Wanted values from the bench change by non-blocking assignment at negedge
// Notes: Adds one falling edge of lag, so bench and model never race

`timescale 1ns/1ps

module sgs_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] req_lvl,
   input wire logic want_force,
   input wire logic [3:0] want_sel,
   output logic [7:0] bank_req,
   output logic override_en,
   output logic [3:0] override_sel
);
   // Single driver per line; lines settle at the first falling edge, inside reset
   // Target only given once the enable is already up, never before it
   always @(negedge ref_clk) begin
      bank_req <= req_lvl;
      override_en <= want_force;
      override_sel <= override_en ? want_sel : 4'h0;
   end
endmodule : sgs_host_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the parameter bank selector
// Assumes: Inputs change at the falling edge of ref_clk
// Notes: Requests reach the selector one cycle after the bench asks

`timescale 1ns/1ps

module tb;
   import sgs_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] req_lvl = 8'h00;
   logic want_force = 1'b0;
   logic [3:0] want_sel = 4'h0;
   logic [2:0] used_banks = 3'h0;
   logic remote_stb = 1'b0;
   logic [3:0] remote_sel = 4'h0;
   logic [7:0] bank_req, active_onehot, bank_enabled, bank_load_default;
   logic override_en, remote_reject, override_reject;
   logic [3:0] override_sel;
   logic [2:0] active_bank;
   int fail_count = 0;
   int n_checks = 0;

   // 200 MHz clock
   initial forever #2.5 ref_clk = ~ref_clk;

   sgs_host_model host_u (.ref_clk(ref_clk), .req_lvl(req_lvl), .want_force(want_force),
      .want_sel(want_sel), .bank_req(bank_req), .override_en(override_en), .override_sel(override_sel));

   sgs_selector #(.NBANK(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bank_req(bank_req),
      .used_banks(used_banks), .override_en(override_en), .override_sel(override_sel),
      .remote_stb(remote_stb), .remote_sel(remote_sel), .active_bank(active_bank),
      .active_onehot(active_onehot), .bank_enabled(bank_enabled), .bank_load_default(bank_load_default),
      .remote_reject(remote_reject), .override_reject(override_reject));

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : step

   task automatic ck(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : ck

   // Index and one-hot must agree
   task automatic act(input int k);
      ck(8'(active_bank), 8'(k));
      ck(active_onehot, 8'h01 << k);
   endtask : act

   // Request held as a level, or released
   task automatic req(input logic [7:0] v);
      req_lvl <= v;
      step(3);
   endtask : req

   // One-cycle pulse on top of what is held
   task automatic pul(input logic [7:0] hold, input logic [7:0] v);
      req_lvl <= hold | v;
      step(1);
      req_lvl <= hold;
      step(3);
   endtask : pul

   task automatic frc(input logic en, input logic [3:0] sel);
      want_force <= en;
      want_sel <= sel;
      step(4);
   endtask : frc

   // Remote strobe lasts exactly one cycle; reject seen next cycle
   task automatic rem(input logic [3:0] sel, input logic rej);
      remote_stb = 1'b1;
      remote_sel = sel;
      step(1);
      remote_stb = 1'b0;
      ck(8'(remote_reject), 8'(rej));
      step(1);
   endtask : rem

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Hang guard
   initial begin
      step(20000);
      fail_count++;
      finish_test();
   end

   initial begin
      step(5);
      rst_n = 1'b1;
      act(0);
      ck(bank_enabled, 8'h01);
      pul(8'h00, 8'h08);
      act(0);
      $display("test reset done");
      used_banks = 3'h7;
      step(1);
      ck(bank_enabled, 8'hff);
      ck(bank_load_default, 8'hfe);
      step(1);
      ck(bank_load_default, 8'h00);
      step(1);
      for (int k = 7; k >= 0; k--) begin
         pul(8'h00, 8'h01 << k);
         act(k);
      end
      pul(8'h00, 8'h28);
      act(3);
      $display("test pulses done");
      req(8'h02);
      act(1);
      pul(8'h02, 8'h10);
      act(1);
      pul(8'h02, 8'h01);
      act(0);
      req(8'h00);
      pul(8'h00, 8'h20);
      req(8'h01);
      act(0);
      pul(8'h01, 8'h04);
      act(0);
      req(8'h80);
      act(7);
      pul(8'h80, 8'h04);
      act(2);
      pul(8'h80, 8'h40);
      act(6);
      $display("test levels done");
      req(8'h01);
      rem(4'h3, 1'b1);
      act(0);
      req(8'h00);
      rem(4'h3, 1'b0);
      act(2);
      $display("test remote done");
      frc(1'b1, 4'h5);
      act(4);
      pul(8'h00, 8'h01);
      act(4);
      frc(1'b1, 4'h0);
      act(4);
      frc(1'b0, 4'h0);
      act(4);
      used_banks = 3'h3;
      step(2);
      act(0);
      frc(1'b1, 4'h7);
      ck(8'(override_reject), 8'h01);
      act(0);
      req(8'h02);
      act(0);
      frc(1'b0, 4'h0);
      act(1);
      $display("test force done");
      finish_test();
   end
endmodule : tb
